// [common/atxi_pkg.sv]
// Purpose: shared constants of the audio transmitter interrupt logic
// Assumes: 8-bit registers reached by index over the control port
// Notes: mask bits are active high (1 = source disabled)
package atxi_pkg;
   localparam logic [7:0] ATXI_STATUS_OFFSET = 8'h04;
   localparam logic [7:0] ATXI_MASK_CTRL_OFFSET = 8'h05;
   // status register fields
   localparam int ATXI_XFER_DONE_BIT = 0;
   localparam int ATXI_SLIP_BLK_BIT = 1;
   // mask and control register fields
   localparam int ATXI_XFER_MASK_BIT = 0;
   localparam int ATXI_SLIP_MASK_BIT = 1;
   localparam int ATXI_SELECT_BIT = 2;
   localparam logic [7:0] ATXI_MASK_CTRL_WMASK = 8'h07;
   // values after reset
   localparam logic [7:0] ATXI_STATUS_RESET = 8'h00;
   localparam logic [7:0] ATXI_MASK_CTRL_RESET = 8'h00;
   localparam logic [7:0] ATXI_RDATA_RESET = 8'h00;
   // bits of the synchroniser chain ahead of logic
   localparam int ATXI_SYNC_STAGES = 2;
endpackage

// [core/atxi_pin_sync.sv]
// Purpose: two-flop synchroniser with rising edge pulse for a pin input
// Assumes: input is asynchronous to i_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module atxi_pin_sync
   import atxi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise
);
   logic [ATXI_SYNC_STAGES-1:0] sync_reg;
   logic prev_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= {sync_reg[ATXI_SYNC_STAGES-2:0], i_pin};
      end
   end

   // edge looks only at the settled stage
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev_reg <= 1'b0;
         o_rise <= 1'b0;
      end else begin
         prev_reg <= sync_reg[ATXI_SYNC_STAGES-1];
         o_rise <= sync_reg[ATXI_SYNC_STAGES-1] & ~prev_reg;
      end
   end

   assign o_level = sync_reg[ATXI_SYNC_STAGES-1];
endmodule

// [core/atxi_core.sv]
// Purpose: interrupt status, mask and open-drain interrupt pin of the transmitter
// Assumes: event inputs are one-cycle pulses from logic on i_clk
// Notes: control mode pin and block start pin are synchronised here
//
// Contract
// - interrupts are produced only in software control mode.
// - three conditions are reported through two status flags; slip and block start share one.
// - the interrupt pin is pulled low for an unmasked condition and otherwise released.
// - set flags hold until a status read clears them; the pin follows the unmasked set flags.
// - per-source mask bits live in the control register at offset 05.
// - a finished channel status buffer transfer sets the transfer flag.
// - status flags are active high.
// - the select bit in register 05 picks slip (0) or block start (1) for the slip flag.
// - in slip mode every dropped or repeated sample sets the slip flag.
// - in block start mode an internal or external block start sets the slip flag.
// - the transfer flag rises when the copy into the transmit buffer completes, if unmasked.
`timescale 1ns/1ps
module atxi_core
   import atxi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_sw_mode_pin,
   input wire logic i_block_start_input,
   input wire logic i_buf_xfer_done,
   input wire logic i_sample_slip,
   input wire logic i_block_start_int,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_int_n_o,
   output logic o_int_n_oe
);
   logic sw_mode;
   logic bls_rise;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] mask_ctrl_reg;
   logic rd_status;
   logic xfer_ev;
   logic slip_ev;
   logic blk_any;
   logic slip_select;

   // one decoder shared by the strobe paths and the read mux
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   atxi_pin_sync u_mode_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_sw_mode_pin),
      .o_level(sw_mode),
      .o_rise()
   );

   atxi_pin_sync u_bls_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_block_start_input),
      .o_level(),
      .o_rise(bls_rise)
   );

   assign rd_status = i_reg_rd && reg_hit(i_reg_addr, ATXI_STATUS_OFFSET);
   assign slip_select = mask_ctrl_reg[ATXI_SELECT_BIT];
   assign blk_any = i_block_start_int | bls_rise;
   // masked sources never reach the flags
   assign xfer_ev = sw_mode & i_buf_xfer_done & ~mask_ctrl_reg[ATXI_XFER_MASK_BIT];
   // one flag, two meanings
   assign slip_ev = sw_mode & ~mask_ctrl_reg[ATXI_SLIP_MASK_BIT]
      & (slip_select ? blk_any : i_sample_slip);

   // set beats clear so a read never swallows a fresh event
   always_comb begin
      status_next = rd_status ? ATXI_STATUS_RESET : status_reg;
      if (xfer_ev) begin
         status_next[ATXI_XFER_DONE_BIT] = 1'b1;
      end
      if (slip_ev) begin
         status_next[ATXI_SLIP_BLK_BIT] = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         status_reg <= ATXI_STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // only the mask and select bits are writable; others read zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mask_ctrl_reg <= ATXI_MASK_CTRL_RESET;
      end else if (i_reg_wr && reg_hit(i_reg_addr, ATXI_MASK_CTRL_OFFSET)) begin
         mask_ctrl_reg <= i_reg_wdata & ATXI_MASK_CTRL_WMASK;
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_reg_rdata <= ATXI_RDATA_RESET;
      end else if (i_reg_rd) begin
         if (reg_hit(i_reg_addr, ATXI_STATUS_OFFSET)) begin
            o_reg_rdata <= status_reg;
         end else if (reg_hit(i_reg_addr, ATXI_MASK_CTRL_OFFSET)) begin
            o_reg_rdata <= mask_ctrl_reg;
         end else begin
            o_reg_rdata <= ATXI_RDATA_RESET;
         end
      end
   end

   // open drain: data always low, enable pulls the line; mask also gates
   // flags raised before the mask was written
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_int_n_o <= 1'b0;
         o_int_n_oe <= 1'b0;
      end else begin
         o_int_n_o <= 1'b0;
         o_int_n_oe <= sw_mode && |(status_next[1:0] & ~mask_ctrl_reg[1:0]);
      end
   end

   a_hw_mode_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !sw_mode |=> !o_int_n_oe)
      else $error("interrupt pin driven outside software mode");

   a_xfer_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sw_mode && i_buf_xfer_done && !mask_ctrl_reg[ATXI_XFER_MASK_BIT]
      |=> status_reg[ATXI_XFER_DONE_BIT])
      else $error("buffer transfer did not set its flag");

   a_slip_mode_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sw_mode && !slip_select && i_sample_slip && !mask_ctrl_reg[ATXI_SLIP_MASK_BIT]
      |=> status_reg[ATXI_SLIP_BLK_BIT])
      else $error("sample slip did not set slip flag");

   a_blk_mode_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sw_mode && slip_select && blk_any && !mask_ctrl_reg[ATXI_SLIP_MASK_BIT]
      |=> status_reg[ATXI_SLIP_BLK_BIT])
      else $error("block start did not set slip flag");

   a_select_blocks_slip: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      slip_select && !blk_any && !status_reg[ATXI_SLIP_BLK_BIT]
      |=> !status_reg[ATXI_SLIP_BLK_BIT])
      else $error("slip flag set by wrong source");

   a_flags_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !rd_status |=> (status_reg & $past(status_reg)) == $past(status_reg))
      else $error("status flag dropped without a read");

   a_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd_status && !xfer_ev && !slip_ev |=> status_reg == ATXI_STATUS_RESET && !o_int_n_oe)
      else $error("status read did not clear flags and pin");

   a_set_wins_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd_status && xfer_ev |=> status_reg[ATXI_XFER_DONE_BIT])
      else $error("event lost at status read");

   a_pin_low_on_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sw_mode && $rose(status_reg[ATXI_XFER_DONE_BIT]) && !mask_ctrl_reg[ATXI_XFER_MASK_BIT]
      |-> o_int_n_oe && !o_int_n_o)
      else $error("interrupt pin not pulled low");

   a_mask_blocks_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      mask_ctrl_reg[ATXI_XFER_MASK_BIT] && !status_reg[ATXI_XFER_DONE_BIT]
      |=> !status_reg[ATXI_XFER_DONE_BIT])
      else $error("masked source set its flag");

   a_read_returns: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd_status |=> o_reg_rdata == $past(status_reg))
      else $error("status read returned wrong value");

   a_pin_data_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !o_int_n_o)
      else $error("interrupt pin data driven high");

   a_pin_holds_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sw_mode && !rd_status && status_reg[ATXI_SLIP_BLK_BIT]
      && !mask_ctrl_reg[ATXI_SLIP_MASK_BIT] |=> o_int_n_oe)
      else $error("interrupt pin released before a status read");

   a_slip_mask_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      mask_ctrl_reg[ATXI_SLIP_MASK_BIT] && !status_reg[ATXI_SLIP_BLK_BIT]
      |=> !status_reg[ATXI_SLIP_BLK_BIT])
      else $error("masked slip source set its flag");

   a_slip_mode_blind: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !slip_select && !i_sample_slip && !status_reg[ATXI_SLIP_BLK_BIT]
      |=> !status_reg[ATXI_SLIP_BLK_BIT])
      else $error("block start seen in slip mode");

   a_hw_mode_no_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !sw_mode && !status_reg[ATXI_XFER_DONE_BIT] |=> !status_reg[ATXI_XFER_DONE_BIT])
      else $error("flag set outside software mode");

   a_slip_wins_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd_status && slip_ev |=> status_reg[ATXI_SLIP_BLK_BIT])
      else $error("slip event lost at status read");

   // spare bits must never read back as a flag
   a_status_spare_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      status_reg[7:2] == 6'h00)
      else $error("spare status bit set");

   a_ctrl_spare_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mask_ctrl_reg & ~ATXI_MASK_CTRL_WMASK) == 8'h00)
      else $error("spare control bit set");

   a_ctrl_write_lands: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_reg_wr && reg_hit(i_reg_addr, ATXI_MASK_CTRL_OFFSET)
      |=> mask_ctrl_reg == ($past(i_reg_wdata) & ATXI_MASK_CTRL_WMASK))
      else $error("control write did not land");
endmodule

// [verif/atxi_host.sv]
// Purpose: host model driving the register port and watching the interrupt line
// Assumes: one byte per access, strobes one cycle wide
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module atxi_host (
   input wire logic i_clk,
   input wire logic i_int_n_o,
   input wire logic i_int_n_oe,
   input wire logic [7:0] i_rdata,
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata,
   output logic o_int_line
);
   // external pull-up wins whenever the pin is let go
   assign o_int_line = i_int_n_oe ? i_int_n_o : 1'b1;
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
   // status is read to learn the cause of a low interrupt line
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(posedge i_clk);
      #1 d = i_rdata;
   endtask
endmodule

// [verif/atxi_core_bench.sv]
// Purpose: self-checking bench of the transmitter interrupt logic
// Assumes: event inputs are one-cycle pulses on the master clock
// Notes: waits are fixed counts from the hand-over latencies
`timescale 1ns/1ps
module atxi_core_bench;
   import atxi_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sw = 1'b0;
   logic block_start_input = 1'b0;
   logic [2:0] evt = 3'b000;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, int_o, int_oe, line;
   int fail_count = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   atxi_core dut (.i_clk(clk), .i_rst_n(rst_n), .i_sw_mode_pin(sw),
      .i_block_start_input(block_start_input), .i_buf_xfer_done(evt[0]), .i_sample_slip(evt[1]),
      .i_block_start_int(evt[2]), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_int_n_o(int_o), .o_int_n_oe(int_oe));
   atxi_host host (.i_clk(clk), .i_int_n_o(int_o), .i_int_n_oe(int_oe), .i_rdata(rdata),
      .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .o_int_line(line));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle pulse, returns once the flag edge has landed
   task automatic pulse(input logic [2:0] m);
      @(posedge clk);
      evt <= m;
      @(posedge clk);
      evt <= 3'b000;
      @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, ATXI_STATUS_RESET);
      host.rd(ATXI_MASK_CTRL_OFFSET, d);
      chk(d, ATXI_MASK_CTRL_RESET);
      host.rd(8'h06, d);
      chk(d, 8'h00);
      pulse(3'b011);
      chk({7'h00, line}, 8'h01);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h00);
      $display("test hardware mode done");
      @(posedge clk);
      sw <= 1'b1;
      repeat (3) @(posedge clk);
      pulse(3'b001);
      chk({7'h00, line}, 8'h00);
      pulse(3'b010);
      chk({7'h00, line}, 8'h00);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h03);
      chk({7'h00, line}, 8'h01);
      pulse(3'b100);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h00);
      $display("test slip mode done");
      host.wr(ATXI_MASK_CTRL_OFFSET, 8'h04);
      pulse(3'b100);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h02);
      pulse(3'b010);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h00);
      @(posedge clk);
      block_start_input <= 1'b1;
      repeat (5) @(posedge clk);
      block_start_input <= 1'b0;
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h02);
      $display("test block start mode done");
      host.wr(ATXI_MASK_CTRL_OFFSET, 8'hff);
      host.rd(ATXI_MASK_CTRL_OFFSET, d);
      chk(d, 8'h07);
      pulse(3'b111);
      chk({7'h00, line}, 8'h01);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h00);
      $display("test mask done");
      host.wr(ATXI_MASK_CTRL_OFFSET, 8'h00);
      // event lands in the very cycle of the clearing read
      fork
         host.rd(ATXI_STATUS_OFFSET, d);
         pulse(3'b001);
      join
      chk(d, 8'h00);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h01);
      $display("test read collision done");
      pulse(3'b001);
      chk({7'h00, line}, 8'h00);
      // masking a raised flag lets the pin go but keeps the flag
      host.wr(ATXI_MASK_CTRL_OFFSET, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      chk({7'h00, line}, 8'h01);
      host.wr(ATXI_STATUS_OFFSET, 8'hff);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h01);
      host.wr(ATXI_MASK_CTRL_OFFSET, 8'h00);
      pulse(3'b010);
      @(posedge clk);
      sw <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, line}, 8'h01);
      host.rd(ATXI_STATUS_OFFSET, d);
      chk(d, 8'h02);
      $display("test release paths done");
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
